// ### pcg_defines.svh
`ifndef PCG_DEFINES_SVH
`define PCG_DEFINES_SVH

// Register word indices on the plain register port
`define PCG_OFS_CTRL 2'h0
`define PCG_OFS_POLY 2'h1
`define PCG_OFS_WDAT 2'h2
`define PCG_OFS_DAT 2'h3

// Control register field positions
`define PCG_CTRL_POLY_LENGTH_FIELD_LSB 0
`define PCG_CTRL_POLY_LENGTH_FIELD_MSB 3
`define PCG_CTRL_GO_BIT 4
`define PCG_CTRL_EMPTY_BIT 6
`define PCG_CTRL_FULL_BIT 7
`define PCG_CTRL_COUNT_LSB 8
`define PCG_CTRL_COUNT_MSB 12
`define PCG_CTRL_SIDL_BIT 13

// Reset values
`define PCG_POLY_LENGTH_FIELD_RST 4'h0
`define PCG_POLY_RST 15'h0000
`define PCG_COUNT_RST 5'h00
`define PCG_WORD_RST 16'h0000

// FIFO depth selection
`define PCG_POLY_LENGTH_FIELD_WIDE_MIN 4'h7
`define PCG_DEPTH_WIDE 5'h08
`define PCG_DEPTH_NARROW 5'h10
`define PCG_PTR_MASK_WIDE 4'h7
`define PCG_PTR_MASK_NARROW 4'hf

// Engine throughput: data bits consumed per clock
`define PCG_BITS_PER_CLK 5'h02

`endif

// ### pcg_pkg.sv
package pcg_pkg;

   // Shift engine states, one-hot
   typedef enum logic [1:0] {
      PCG_ENG_IDLE = 2'h1,
      PCG_ENG_SHIFT = 2'h2
   } pcg_eng_state_e;

   typedef logic [15:0] pcg_word_t;

endpackage : pcg_pkg

// ### pcg_shift_engine.sv
`include "pcg_defines.svh"

module pcg_shift_engine
   import pcg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [3:0] poly_length_field,
   input wire logic [15:1] polyTerms,
   input wire logic load,
   input wire pcg_word_t loadWord,
   input wire logic seedWr,
   input wire pcg_word_t seedWord,
   output logic ready,
   output pcg_word_t result
);

   pcg_eng_state_e state_r;
   logic [4:0] bitsLeft_r;
   pcg_word_t data_r;
   pcg_word_t crc_r;
   pcg_word_t mask;
   pcg_word_t crcOne;
   pcg_word_t crcTwo;
   pcg_word_t crcNxt;

   // One serial step; x^0 always fed back, top term implied by the length
   function automatic pcg_word_t crcStep(input pcg_word_t c, input logic b,
                                         input logic [3:0] len, input logic [15:1] terms,
                                         input pcg_word_t m);
      pcg_word_t n;
      logic fb;
      fb = b ^ c[len];
      n = {c[14:0], fb};
      for (int i = 1; i < 16; i++) begin
         if (terms[i]) begin
            n[i] = n[i] ^ fb;
         end
      end
      return n & m;
   endfunction : crcStep

   assign mask = 16'hffff >> (4'hf - poly_length_field);

   // Two bits per clock; an odd last bit takes a single step
   always_comb begin
      crcOne = crcStep(crc_r, data_r[15], poly_length_field, polyTerms, mask);
      crcTwo = crcStep(crcOne, data_r[14], poly_length_field, polyTerms, mask);
      if (state_r != PCG_ENG_SHIFT) begin
         crcNxt = crc_r;
      end else if (bitsLeft_r >= `PCG_BITS_PER_CLK) begin
         crcNxt = crcTwo;
      end else begin
         crcNxt = crcOne;
      end
   end

   // Accepts the next word in the last shifting cycle so the stream never gaps
   assign ready = (state_r == PCG_ENG_IDLE) || (bitsLeft_r <= `PCG_BITS_PER_CLK);
   assign result = crc_r;

   // Shift state and data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= PCG_ENG_IDLE;
         bitsLeft_r <= 5'h00;
         data_r <= `PCG_WORD_RST;
      end else if (ce) begin
         case (state_r)
            PCG_ENG_IDLE: begin
               if (load) begin
                  state_r <= PCG_ENG_SHIFT;
               end
            end
            PCG_ENG_SHIFT: begin
               if (ready && !load) begin
                  state_r <= PCG_ENG_IDLE;
               end
            end
            default: begin
               state_r <= PCG_ENG_IDLE;
            end
         endcase
         if (load) begin
            bitsLeft_r <= {1'b0, poly_length_field} + 5'h01;
            data_r <= loadWord << (4'hf - poly_length_field);
         end else if (state_r == PCG_ENG_SHIFT) begin
            bitsLeft_r <= ready ? 5'h00 : bitsLeft_r - `PCG_BITS_PER_CLK;
            data_r <= data_r << 2;
         end
      end
   end

   // Checksum register; a software seed write wins over shifting
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         crc_r <= `PCG_WORD_RST;
      end else if (ce) begin
         if (seedWr) begin
            crc_r <= seedWord & mask;
         end else begin
            crc_r <= crcNxt;
         end
      end
   end

endmodule : pcg_shift_engine

// ### pcg_crc_gen.sv
// Behaviour
// - Software programs feedback terms and polynomial length
// - x^0 and x^16 terms always fed back; here the top term is x^(length+1), so x^16 only at length 15
// - FIFO depth 8 above length seven, else 16
// - Word is length plus one bits; extras ignored
// - Count increments when the top byte lands
// - Started with words waiting: move word, decrement count
// - Last bit leaves half-length cycles after empty
// - Full flag when count reaches FIFO depth
// - Empty flag when count reaches zero
// - Write while full wraps count, no interrupt
// - Interrupt when count drops from one to zero
// - Length field holds polynomial length minus one
// - Stop-in-idle bit halts block in idle; here only the pop and the engine, seed writes included, halt; other writes and flags run on
// - Sleep freezes state, resumes when clocks return
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.

`include "pcg_defines.svh"

module pcg_crc_gen
   import pcg_pkg::*;
#(
   parameter int MAX_DEPTH = 16
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic idleMode,
   input wire logic [1:0] addr,
   input wire logic [15:0] wrData,
   input wire logic [1:0] wrBe,
   input wire logic wrStb,
   input wire logic rdStb,
   output logic [15:0] rdData,
   output logic crcIrq,
   output logic fifoFull,
   output logic fifoEmpty
);

   // Configuration held by software
   logic [3:0] polyLengthField_r;
   logic [15:1] polyTerms_r;
   logic shifterStart_r;
   logic stopInIdle_r;

   // FIFO storage and bookkeeping
   pcg_word_t mem [MAX_DEPTH];
   logic [3:0] wrPtr_r;
   logic [3:0] rdPtr_r;
   logic [4:0] validWordCount_r;
   logic [4:0] countNxt;
   pcg_word_t stage_r;

   // Status and bus outputs
   logic fullFlag_r;
   logic emptyFlag_r;
   logic irq_r;
   logic [15:0] rdData_r;

   // Decoded strobes and derived values
   logic runCe;
   logic wrCtrl;
   logic wrPoly;
   logic wrWdat;
   logic wrDat;
   logic plenWide;
   logic [4:0] depth;
   logic [3:0] ptrMask;
   pcg_word_t widthMask;
   logic msbLane;
   logic push;
   logic wrapWrite;
   logic pop;
   pcg_word_t pushWord;
   pcg_word_t seedWord;
   logic engReady;
   pcg_word_t result;

   // Sleep is clkEn low; stop-in-idle gates only the draining side
   assign runCe = clkEn && !(idleMode && stopInIdle_r);

   // Register decode
   assign wrCtrl = wrStb && (addr == `PCG_OFS_CTRL);
   assign wrPoly = wrStb && (addr == `PCG_OFS_POLY);
   assign wrWdat = wrStb && (addr == `PCG_OFS_WDAT);
   assign wrDat = wrStb && (addr == `PCG_OFS_DAT);

   // Depth and data width follow the length field
   assign plenWide = polyLengthField_r > `PCG_POLY_LENGTH_FIELD_WIDE_MIN;
   assign depth = plenWide ? `PCG_DEPTH_WIDE : `PCG_DEPTH_NARROW;
   assign ptrMask = plenWide ? `PCG_PTR_MASK_WIDE : `PCG_PTR_MASK_NARROW;
   assign widthMask = 16'hffff >> (4'hf - polyLengthField_r);

   // The byte holding the word's top bit is the one that completes a word
   assign msbLane = plenWide ? wrBe[1] : wrBe[0];

   // Merge the written lanes over the staged lanes, dropping bits above the width
   always_comb begin
      pushWord = stage_r;
      if (wrBe[0]) begin
         pushWord[7:0] = wrData[7:0];
      end
      if (wrBe[1]) begin
         pushWord[15:8] = wrData[15:8];
      end
      pushWord = pushWord & widthMask;
   end

   // Seed merge keeps the unwritten lane of the current checksum
   always_comb begin
      seedWord = result;
      if (wrBe[0]) begin
         seedWord[7:0] = wrData[7:0];
      end
      if (wrBe[1]) begin
         seedWord[15:8] = wrData[15:8];
      end
   end

   // Push, wrap and pop decisions
   assign push = wrWdat && msbLane;
   assign wrapWrite = push && fullFlag_r;
   assign pop = runCe && shifterStart_r && (validWordCount_r != 5'h00) && engReady && !wrapWrite;

   // Next count; a write into a full FIFO rolls the count to zero
   always_comb begin
      if (wrapWrite) begin
         countNxt = 5'h00;
      end else begin
         countNxt = validWordCount_r + {4'h0, push} - {4'h0, pop};
      end
   end

   // Control register: length, start, stop-in-idle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         polyLengthField_r <= `PCG_POLY_LENGTH_FIELD_RST;
         shifterStart_r <= 1'b0;
         stopInIdle_r <= 1'b0;
      end else if (clkEn) begin
         if (wrCtrl && wrBe[0]) begin
            polyLengthField_r <= wrData[`PCG_CTRL_POLY_LENGTH_FIELD_MSB:`PCG_CTRL_POLY_LENGTH_FIELD_LSB];
            shifterStart_r <= wrData[`PCG_CTRL_GO_BIT];
         end
         if (wrCtrl && wrBe[1]) begin
            stopInIdle_r <= wrData[`PCG_CTRL_SIDL_BIT];
         end
      end
   end

   // Polynomial term enables; bit 0 has no storage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         polyTerms_r <= `PCG_POLY_RST;
      end else if (clkEn) begin
         if (wrPoly && wrBe[0]) begin
            polyTerms_r[7:1] <= wrData[7:1];
         end
         if (wrPoly && wrBe[1]) begin
            polyTerms_r[15:8] <= wrData[15:8];
         end
      end
   end

   // Staging holds the lower byte until the top byte completes a wide word
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage_r <= `PCG_WORD_RST;
      end else if (clkEn) begin
         if (wrWdat) begin
            stage_r <= push ? `PCG_WORD_RST : pushWord;
         end
      end
   end

   // FIFO storage; no reset needed, the count guards stale entries
   always_ff @(posedge clk) begin
      if (clkEn && push && !wrapWrite) begin
         mem[wrPtr_r] <= pushWord;
      end
   end

   // Write pointer, wrapping at the active depth
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtr_r <= 4'h0;
      end else if (clkEn) begin
         if (wrapWrite) begin
            wrPtr_r <= 4'h0;
         end else if (push) begin
            wrPtr_r <= (wrPtr_r + 4'h1) & ptrMask;
         end
      end
   end

   // Read pointer; restarts with the write pointer on a wrap
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdPtr_r <= 4'h0;
      end else if (clkEn) begin
         if (wrapWrite) begin
            rdPtr_r <= 4'h0;
         end else if (pop) begin
            rdPtr_r <= (rdPtr_r + 4'h1) & ptrMask;
         end
      end
   end

   // Valid-word count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         validWordCount_r <= `PCG_COUNT_RST;
      end else if (clkEn) begin
         validWordCount_r <= countNxt;
      end
   end

   // Flags track the next count so they agree with the count on every read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fullFlag_r <= 1'b0;
         emptyFlag_r <= 1'b1;
      end else if (clkEn) begin
         fullFlag_r <= countNxt == depth;
         emptyFlag_r <= countNxt == 5'h00;
      end
   end

   // Interrupt pulse on the one-to-zero step; a wrap never starts at one
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_r <= 1'b0;
      end else if (clkEn) begin
         irq_r <= (validWordCount_r == 5'h01) && (countNxt == 5'h00) && !wrapWrite;
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdData_r <= 16'h0000;
      end else if (clkEn) begin
         rdData_r <= 16'h0000;
         if (rdStb) begin
            case (addr)
               `PCG_OFS_CTRL: begin
                  rdData_r[`PCG_CTRL_POLY_LENGTH_FIELD_MSB:`PCG_CTRL_POLY_LENGTH_FIELD_LSB] <= polyLengthField_r;
                  rdData_r[`PCG_CTRL_GO_BIT] <= shifterStart_r;
                  rdData_r[`PCG_CTRL_EMPTY_BIT] <= emptyFlag_r;
                  rdData_r[`PCG_CTRL_FULL_BIT] <= fullFlag_r;
                  rdData_r[`PCG_CTRL_COUNT_MSB:`PCG_CTRL_COUNT_LSB] <= validWordCount_r;
                  rdData_r[`PCG_CTRL_SIDL_BIT] <= stopInIdle_r;
               end
               `PCG_OFS_POLY: begin
                  rdData_r <= {polyTerms_r, 1'b0};
               end
               `PCG_OFS_WDAT: begin
                  rdData_r <= result;
               end
               `PCG_OFS_DAT: begin
                  rdData_r <= result;
               end
               default: begin
                  rdData_r <= 16'h0000;
               end
            endcase
         end
      end
   end

   // Serial engine: started by the start bit, drains one word per pop
   pcg_shift_engine u_engine (
      .clk(clk),
      .rst(rst),
      .ce(runCe),
      .poly_length_field(polyLengthField_r),
      .polyTerms(polyTerms_r),
      .load(pop),
      .loadWord(mem[rdPtr_r]),
      .seedWr(wrDat && clkEn),
      .seedWord(seedWord),
      .ready(engReady),
      .result(result)
   );

   // Outputs
   assign rdData = rdData_r;
   assign crcIrq = irq_r;
   assign fifoFull = fullFlag_r;
   assign fifoEmpty = emptyFlag_r;

endmodule : pcg_crc_gen

// ### pcg_crc_gen_props.sv
module pcg_crc_gen_chk
   import pcg_pkg::*;
#(
   parameter int MAX_DEPTH = 16
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic idleMode,
   input wire logic [1:0] addr,
   input wire logic [15:0] wrData,
   input wire logic [1:0] wrBe,
   input wire logic wrStb,
   input wire logic rdStb,
   input wire logic [15:0] rdData,
   input wire logic crcIrq,
   input wire logic fifoFull,
   input wire logic fifoEmpty
);
   timeunit 1ns;
   timeprecision 1ns;
   // One clock domain, so clock and reset are given once for all checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Read data only stands in the cycle after an accepted read strobe
   chk_rd_quiet: assert property (!$past(rdStb) && $past(clkEn) |-> rdData == 16'h0000)
      else $error("read data not zero outside read cycle");
   // A count cannot be both zero and at depth
   chk_flags_excl: assert property (!(fifoFull && fifoEmpty))
      else $error("full and empty flags both set");
   // Interrupt only follows a drop from one word to none, never a wrap
   chk_irq_cause: assert property (crcIrq && $past(clkEn)
      |-> fifoEmpty && !$past(fifoEmpty) && !$past(fifoFull))
      else $error("interrupt without a one to zero drop");
   // A drop to empty that is not a wrap raises the interrupt at the same edge
   chk_irq_follow: assert property ($rose(fifoEmpty) && !$past(fifoFull) |-> crcIrq)
      else $error("empty rose without interrupt");
   // Wrap from full leaves the interrupt quiet
   chk_wrap_quiet: assert property ($fell(fifoFull) && fifoEmpty |-> !crcIrq)
      else $error("interrupt after wrap");
   // Interrupt is a single pulse while clocks run
   chk_irq_pulse: assert property (crcIrq && clkEn |=> !crcIrq)
      else $error("interrupt longer than one cycle");
   // A full word push into a FIFO that is not full leaves at least one word
   chk_push_fill: assert property (wrStb && clkEn && addr == 2'h2 && wrBe == 2'h3 && !fifoFull
      |=> !fifoEmpty)
      else $error("push left fifo empty");
   // Control read mirrors the flags and shows unused bits as zero
   chk_ctrl_view: assert property (rdStb && clkEn && addr == 2'h0 |=> rdData[7] == $past(fifoFull)
      && rdData[6] == $past(fifoEmpty) && rdData[5] == 1'b0 && rdData[15:14] == 2'h0)
      else $error("control read disagrees with flags");
   // Lowest polynomial bit has no storage
   chk_poly_zero: assert property (rdStb && clkEn && addr == 2'h1 |=> rdData[0] == 1'b0)
      else $error("polynomial bit zero reads one");
   // Sleep freezes every output
   chk_sleep_hold: assert property (!clkEn |=> $stable({rdData, crcIrq, fifoFull, fifoEmpty}))
      else $error("outputs moved while clock disabled");
endmodule : pcg_crc_gen_chk

bind pcg_crc_gen pcg_crc_gen_chk #(.MAX_DEPTH(MAX_DEPTH)) pcg_crc_gen_chk_i (.clk(clk), .rst(rst),
   .clkEn(clkEn), .idleMode(idleMode), .addr(addr), .wrData(wrData), .wrBe(wrBe), .wrStb(wrStb),
   .rdStb(rdStb), .rdData(rdData), .crcIrq(crcIrq), .fifoFull(fifoFull), .fifoEmpty(fifoEmpty));

// ### tb_top.sv
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, clkEn, idleMode, wrStb, rdStb, crcIrq, fifoFull, fifoEmpty;
   logic [1:0] addr, wrBe;
   logic [15:0] wrData, rdData, rv;
   int miscompares = 0;
   int checks = 0;
   int irqCount = 0;

   pcg_crc_gen #(.MAX_DEPTH(16)) pcg_crc_gen_i (.clk(clk), .rst(rst), .clkEn(clkEn), .idleMode(idleMode),
      .addr(addr), .wrData(wrData), .wrBe(wrBe), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
      .crcIrq(crcIrq), .fifoFull(fifoFull), .fifoEmpty(fifoEmpty));

   // Free running 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Interrupt pulses counted so tests can tell whether one came
   always @(posedge clk) begin
      if (crcIrq === 1'b1) irqCount++;
   end

   task automatic wr(input logic [1:0] a, input logic [15:0] d, input logic [1:0] be);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrBe <= be;
      wrStb <= 1'b1;
      @(posedge clk);
      wrStb <= 1'b0;
   endtask : wr

   // Data is taken one step after the edge so the registered answer has landed
   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge clk);
      rdStb <= 1'b0;
      #1 d = rdData;
   endtask : rd

   // Bounded wait for the next interrupt pulse
   task automatic waitIrq(input int lim);
      int c0;
      c0 = irqCount;
      for (int i = 0; i < lim && irqCount == c0; i++) @(posedge clk);
      #1 `CHK(irqCount, c0 + 1)
   endtask : waitIrq

   // Independent reference: MSB first, feedback into enabled terms, length plus one bits
   function automatic logic [15:0] crcRef(logic [15:0] c, logic [15:0] d, int l, logic [15:0] t);
      logic fb;
      logic [15:0] m;
      m = 16'hffff >> (15 - l);
      c = c & m;
      for (int i = l; i >= 0; i--) begin
         fb = d[i] ^ c[l];
         c = ({c[14:0], fb} ^ (fb ? (t & 16'hfffe) : 16'h0000)) & m;
      end
      return c;
   endfunction : crcRef

   task automatic t_reset();
      rd(2'h0, rv);
      `CHK(rv, 16'h0040)
      rd(2'h1, rv);
      `CHK(rv, 16'h0000)
      wr(2'h1, 16'hffff, 2'h3);
      rd(2'h1, rv);
      `CHK(rv, 16'hfffe)
      wr(2'h0, 16'hffff, 2'h3);
      rd(2'h0, rv);
      `CHK(rv, 16'h205f)
      wr(2'h0, 16'h0000, 2'h3);
      $display("test reset done");
   endtask : t_reset

   // Fill to depth for a short and a long polynomial, then push once more
   task automatic t_depth();
      int c0;
      for (int k = 0; k < 2; k++) begin
         wr(2'h0, k ? 16'h000f : 16'h0007, 2'h3);
         for (int i = 0; i < (k ? 8 : 16); i++) wr(2'h2, 16'(i), 2'h3);
         #1 `CHK(fifoFull, 1'b1)
         rd(2'h0, rv);
         `CHK(rv[12:8], k ? 5'h08 : 5'h10)
         c0 = irqCount;
         wr(2'h2, 16'h00aa, 2'h3);
         repeat (3) @(posedge clk);
         #1 `CHK({fifoFull, fifoEmpty}, 2'h1)
         `CHK(irqCount, c0)
      end
      $display("test depth done");
   endtask : t_depth

   // Sixteen bit polynomial, bytes staged, two words chained
   task automatic t_crc16();
      wr(2'h0, 16'h000f, 2'h3);
      wr(2'h1, 16'h1020, 2'h3);
      wr(2'h3, 16'hffff, 2'h3);
      wr(2'h2, 16'h0034, 2'h1);
      rd(2'h0, rv);
      `CHK(rv[12:8], 5'h00)
      wr(2'h2, 16'h1200, 2'h2);
      rd(2'h0, rv);
      `CHK(rv[12:8], 5'h01)
      wr(2'h2, 16'habcd, 2'h3);
      wr(2'h0, 16'h001f, 2'h3);
      waitIrq(20);
      repeat (8) @(posedge clk);
      rd(2'h2, rv);
      `CHK(rv, crcRef(crcRef(16'hffff, 16'h1234, 15, 16'h1020), 16'habcd, 15, 16'h1020))
      wr(2'h0, 16'h0000, 2'h3);
      $display("test crc16 done");
   endtask : t_crc16

   // Six bit word: top two bits of the written lower byte dropped
   task automatic t_crc6();
      wr(2'h0, 16'h0005, 2'h3);
      wr(2'h1, 16'h0002, 2'h3);
      wr(2'h3, 16'h0000, 2'h3);
      wr(2'h2, 16'h00ff, 2'h1);
      wr(2'h0, 16'h0015, 2'h3);
      waitIrq(20);
      `CHK(fifoEmpty, 1'b1)
      repeat (3) @(posedge clk);
      rd(2'h3, rv);
      `CHK(rv, crcRef(16'h0000, 16'h003f, 5, 16'h0002))
      wr(2'h0, 16'h0000, 2'h3);
      $display("test crc6 done");
   endtask : t_crc6

   // Stop-in-idle holds the pop; sleep freezes; both resume
   task automatic t_idle();
      int c0;
      wr(2'h2, 16'h5555, 2'h3);
      idleMode <= 1'b1;
      wr(2'h0, 16'h201f, 2'h3);
      c0 = irqCount;
      repeat (10) @(posedge clk);
      clkEn <= 1'b0;
      repeat (5) @(posedge clk);
      clkEn <= 1'b1;
      #1 `CHK(irqCount, c0)
      `CHK(fifoEmpty, 1'b0)
      idleMode <= 1'b0;
      waitIrq(20);
      wr(2'h0, 16'h0000, 2'h3);
      $display("test idle done");
   endtask : t_idle

   task automatic summarize();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      summarize();
   end

   initial begin
      rst = 1'b1;
      clkEn = 1'b1;
      idleMode = 1'b0;
      addr = 2'h0;
      wrData = 16'h0000;
      wrBe = 2'h0;
      wrStb = 1'b0;
      rdStb = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_depth();
      t_crc16();
      t_crc6();
      t_idle();
      summarize();
   end
endmodule : tb_top
